// ---- hw/slp_line_protect.sv ----
// protection switch controller for a working/protection line pair
// Notes on behaviour
// - working fail or degrade selects healthy protection
// - revertive mode returns after wait-to-restore
// - automatic return only while working line is clear
// - configure defaults revertive on 1:1 only
// - exactly one line active at once
// - idle pair keeps working line active
// - annex B is bidirectional, nonrevertive, rejects others
// - annex B refuses manual switch requests
// - manual request forces chosen line otherwise
// - last manual request kept for reapplying
// - 1+1 partner: same port, adjacent card
// - 1:1 partner: adjacent line, same card
// - ends coordinate through in-band request bits
// - newly configured pair starts on working line
// - 1+1 transmit bridges payload onto both lines
// - receive forwards only the selected line
`timescale 1ns/1ps
`default_nettype none
`include "slp_regs.svh"
module slp_line_protect
    import slp_pkg::*;
#(
    parameter int unsigned WTR_UNIT_CYCLES = `SLP_WTR_UNIT_CYCLES
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             IRQ_O,
    input  wire logic        WORK_LOS_I,
    input  wire logic        WORK_LOF_I,
    input  wire logic        WORK_AIS_I,
    input  wire logic        WORK_BER_SF_I,
    input  wire logic        WORK_BER_SD_I,
    input  wire logic        PROT_LOS_I,
    input  wire logic        PROT_LOF_I,
    input  wire logic        PROT_AIS_I,
    input  wire logic        PROT_BER_SF_I,
    input  wire logic        PROT_BER_SD_I,
    input  wire logic [1:0]  RX_APS_REQ_I,
    output logic      [1:0]  TX_APS_REQ_O,
    input  wire logic [7:0]  RX_WORK_DATA_I,
    input  wire logic        RX_WORK_VALID_I,
    input  wire logic [7:0]  RX_PROT_DATA_I,
    input  wire logic        RX_PROT_VALID_I,
    output logic      [7:0]  RX_DATA_O,
    output logic             RX_VALID_O,
    input  wire logic [7:0]  TX_DATA_I,
    input  wire logic        TX_VALID_I,
    output logic      [7:0]  TX_WORK_DATA_O,
    output logic             TX_WORK_VALID_O,
    output logic      [7:0]  TX_PROT_DATA_O,
    output logic             TX_PROT_VALID_O,
    output logic             WORK_ACTIVE_O,
    output logic             PROT_ACTIVE_O
);

    function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    slp_scheme_t           scheme_reg, scheme_next;
    slp_manual_t           manual_reg, manual_next;
    logic                  rev_reg, rev_next;
    logic                  bidir_reg, bidir_next;
    logic [2:0]            port_reg, port_next;
    logic [15:0]           wtr_reg, wtr_next;
    logic                  man_act_reg, man_act_next;
    logic [`SLP_IRQ_W-1:0] irq_reg, irq_next;
    logic [`SLP_IRQ_W-1:0] mask_reg, mask_next;
    logic                  ack_reg, ack_next;
    logic [31:0]           dat_reg, dat_next;
    slp_state_t            state_reg, state_next;
    logic                  cfg_pulse, ev_reject, ev_refused, ev_switch;
    logic                  tmr_start, tmr_cancel, tmr_run, tmr_exp;
    logic                  take, wr, man_wr;
    logic [31:0]           ctrl_rd, status_rd, m;
    logic                  work_sf, work_sd, work_fail, prot_alarm, far_prot, forced, released;
    logic [2:0]            part_port;
    logic                  part_card;

    assign work_sf    = WORK_LOS_I | WORK_LOF_I | WORK_AIS_I | WORK_BER_SF_I;
    assign work_sd    = WORK_BER_SD_I;
    assign work_fail  = work_sf | work_sd;
    assign prot_alarm = PROT_LOS_I | PROT_LOF_I | PROT_AIS_I | PROT_BER_SF_I | PROT_BER_SD_I;
    // far end asks for protection; only honoured in bidirectional mode
    assign far_prot   = bidir_reg & RX_APS_REQ_I[0];
    assign forced     = man_act_reg & (scheme_reg != SLP_SCH_ANXB) & (manual_reg != SLP_MAN_CLEAR);
    // a cleared request hands the pair back to automatic control once
    assign released   = man_act_reg & (scheme_reg != SLP_SCH_ANXB) & (manual_reg == SLP_MAN_CLEAR);

    // partner line location
    assign part_card = (scheme_reg != SLP_SCH_1T1);
    assign part_port = (scheme_reg == SLP_SCH_1T1) ? 3'(port_reg + 3'h1) : port_reg;

    assign take   = WB_CYC_I & WB_STB_I & ~ack_reg;
    assign wr     = take & WB_WE_I;
    assign man_wr = wr & (WB_ADR_I == `SLP_ADDR_MANUAL);

    assign ctrl_rd = {24'h000000, 1'b0, port_reg, bidir_reg, rev_reg, scheme_reg};
    always_comb begin
        status_rd = 32'h00000000;
        status_rd[`SLP_ST_PROT_ACT]  = (state_reg != SLP_ST_WORK);
        status_rd[`SLP_ST_WTR_RUN]   = tmr_run;
        status_rd[`SLP_ST_WORK_SF]   = work_sf;
        status_rd[`SLP_ST_WORK_SD]   = work_sd;
        status_rd[`SLP_ST_PROT_ALM]  = prot_alarm;
        status_rd[`SLP_ST_MAN_ACT]   = man_act_reg;
        status_rd[`SLP_ST_PART_CARD] = part_card;
        status_rd[`SLP_ST_PART_PORT +: 3] = part_port;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file and wishbone slave
    always_comb begin
        scheme_next  = scheme_reg;
        manual_next  = manual_reg;
        rev_next     = rev_reg;
        bidir_next   = bidir_reg;
        port_next    = port_reg;
        wtr_next     = wtr_reg;
        man_act_next = man_act_reg;
        mask_next    = mask_reg;
        dat_next     = dat_reg;
        ack_next     = take;
        cfg_pulse    = 1'b0;
        ev_reject    = 1'b0;
        ev_refused   = 1'b0;
        m            = 32'h00000000;
        if (released) begin
            man_act_next = 1'b0;
        end
        if (take && !WB_WE_I) begin
            unique case (WB_ADR_I)
                `SLP_ADDR_CTRL:     dat_next = ctrl_rd;
                `SLP_ADDR_WTR:      dat_next = {16'h0000, wtr_reg};
                `SLP_ADDR_MANUAL:   dat_next = {30'h00000000, manual_reg};
                `SLP_ADDR_STATUS:   dat_next = status_rd;
                `SLP_ADDR_IRQ_STAT: dat_next = {28'h0000000, irq_reg};
                `SLP_ADDR_IRQ_MASK: dat_next = {28'h0000000, mask_reg};
                default:            dat_next = 32'h00000000;
            endcase
        end
        if (wr && WB_ADR_I == `SLP_ADDR_CTRL) begin
            m = wb_merge(ctrl_rd, WB_DAT_I, WB_SEL_I);
            if (m[`SLP_CTRL_CFG]) begin
                if (slp_scheme_t'(m[1:0]) == SLP_SCH_RSVD) begin
                    ev_reject = 1'b1;
                end else begin
                    cfg_pulse    = 1'b1;
                    scheme_next  = slp_scheme_t'(m[1:0]);
                    rev_next     = (slp_scheme_t'(m[1:0]) == SLP_SCH_1T1);
                    bidir_next   = (slp_scheme_t'(m[1:0]) == SLP_SCH_ANXB) | m[`SLP_CTRL_BIDIR];
                    port_next    = m[`SLP_CTRL_PORT_LO +: 3];
                    man_act_next = 1'b0;
                end
            end else if (scheme_reg == SLP_SCH_ANXB && (m[`SLP_CTRL_REV] || !m[`SLP_CTRL_BIDIR])) begin
                ev_reject = 1'b1;
            end else begin
                rev_next   = m[`SLP_CTRL_REV];
                bidir_next = m[`SLP_CTRL_BIDIR];
                port_next  = m[`SLP_CTRL_PORT_LO +: 3];
            end
            // stored request is put back in force after a rebuild
            if (m[`SLP_CTRL_REAPPLY] && !m[`SLP_CTRL_CFG]) begin
                if (scheme_reg == SLP_SCH_ANXB) begin
                    ev_refused = 1'b1;
                end else begin
                    man_act_next = 1'b1;
                end
            end
        end
        if (wr && WB_ADR_I == `SLP_ADDR_WTR) begin
            m        = wb_merge({16'h0000, wtr_reg}, WB_DAT_I, WB_SEL_I);
            wtr_next = m[15:0];
        end
        if (man_wr) begin
            m = wb_merge({30'h00000000, manual_reg}, WB_DAT_I, WB_SEL_I);
            if (scheme_reg == SLP_SCH_ANXB) begin
                ev_refused = 1'b1;
            end else if (slp_manual_t'(m[1:0]) == SLP_MAN_RSVD) begin
                ev_reject = 1'b1;
            end else begin
                manual_next  = slp_manual_t'(m[1:0]);
                man_act_next = 1'b1;
            end
        end
        if (wr && WB_ADR_I == `SLP_ADDR_IRQ_MASK) begin
            m         = wb_merge({28'h0000000, mask_reg}, WB_DAT_I, WB_SEL_I);
            mask_next = m[`SLP_IRQ_W-1:0];
        end
    end

    // write-one-to-clear; an event in the clearing cycle wins
    always_comb begin
        irq_next = irq_reg;
        if (wr && WB_ADR_I == `SLP_ADDR_IRQ_STAT) begin
            irq_next = irq_reg & ~(WB_DAT_I[`SLP_IRQ_W-1:0] & {`SLP_IRQ_W{WB_SEL_I[0]}});
        end
        irq_next[`SLP_IRQ_SWITCH]   = irq_next[`SLP_IRQ_SWITCH] | ev_switch;
        irq_next[`SLP_IRQ_REJECT]   = irq_next[`SLP_IRQ_REJECT] | ev_reject;
        irq_next[`SLP_IRQ_REFUSED]  = irq_next[`SLP_IRQ_REFUSED] | ev_refused;
        irq_next[`SLP_IRQ_WTR_DONE] = irq_next[`SLP_IRQ_WTR_DONE] | tmr_exp;
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            scheme_reg  <= SLP_SCH_1P1;
            manual_reg  <= SLP_MAN_CLEAR;
            rev_reg     <= 1'b0;
            bidir_reg   <= 1'b0;
            port_reg    <= 3'h0;
            wtr_reg     <= `SLP_WTR_RST;
            man_act_reg <= 1'b0;
            irq_reg     <= '0;
            mask_reg    <= '0;
            ack_reg     <= 1'b0;
            dat_reg     <= 32'h00000000;
        end else begin
            scheme_reg  <= scheme_next;
            manual_reg  <= manual_next;
            rev_reg     <= rev_next;
            bidir_reg   <= bidir_next;
            port_reg    <= port_next;
            wtr_reg     <= wtr_next;
            man_act_reg <= man_act_next;
            irq_reg     <= irq_next;
            mask_reg    <= mask_next;
            ack_reg     <= ack_next;
            dat_reg     <= dat_next;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;
    assign IRQ_O    = |(irq_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // line selection
    always_comb begin
        state_next = state_reg;
        tmr_start  = 1'b0;
        tmr_cancel = 1'b0;
        if (cfg_pulse) begin
            state_next = SLP_ST_WORK;
            tmr_cancel = 1'b1;
        end else if (forced) begin
            // forcing overrides alarms; the operator owns the outcome
            state_next = (manual_reg == SLP_MAN_PROT) ? SLP_ST_PROT : SLP_ST_WORK;
            tmr_cancel = 1'b1;
        end else if (released && !work_fail && !far_prot) begin
            state_next = SLP_ST_WORK;
            tmr_cancel = 1'b1;
        end else begin
            unique case (state_reg)
                SLP_ST_WORK: begin
                    if ((work_fail || far_prot) && !prot_alarm) begin
                        state_next = SLP_ST_PROT;
                    end
                end
                SLP_ST_PROT: begin
                    if (rev_reg && !work_fail && !far_prot) begin
                        state_next = SLP_ST_WTR;
                        tmr_start  = 1'b1;
                    end else if (!rev_reg && prot_alarm && !work_fail) begin
                        state_next = SLP_ST_WORK;
                    end
                end
                SLP_ST_WTR: begin
                    if (work_fail || far_prot) begin
                        state_next = SLP_ST_PROT;
                        tmr_cancel = 1'b1;
                    end else if (prot_alarm || tmr_exp) begin
                        state_next = SLP_ST_WORK;
                        tmr_cancel = 1'b1;
                    end else if (!rev_reg) begin
                        state_next = SLP_ST_PROT;
                        tmr_cancel = 1'b1;
                    end
                end
                default: state_next = SLP_ST_WORK;
            endcase
        end
    end

    assign ev_switch = (state_next == SLP_ST_WORK) != (state_reg == SLP_ST_WORK);

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= SLP_ST_WORK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign WORK_ACTIVE_O = (state_reg == SLP_ST_WORK);
    assign PROT_ACTIVE_O = (state_reg != SLP_ST_WORK);

    slp_wtr_timer #(
        .UNIT_CYCLES (WTR_UNIT_CYCLES)
    ) u_wtr (
        .clk_i     (CLK_SYS_I),
        .rst_i     (RST_I),
        .start_i   (tmr_start),
        .cancel_i  (tmr_cancel),
        .period_i  (wtr_reg),
        .running_o (tmr_run),
        .expired_o (tmr_exp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bridge and selector
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            RX_DATA_O       <= 8'h00;
            RX_VALID_O      <= 1'b0;
            TX_WORK_DATA_O  <= 8'h00;
            TX_WORK_VALID_O <= 1'b0;
            TX_PROT_DATA_O  <= 8'h00;
            TX_PROT_VALID_O <= 1'b0;
            TX_APS_REQ_O    <= 2'h0;
        end else begin
            RX_DATA_O       <= PROT_ACTIVE_O ? RX_PROT_DATA_I : RX_WORK_DATA_I;
            RX_VALID_O      <= PROT_ACTIVE_O ? RX_PROT_VALID_I : RX_WORK_VALID_I;
            TX_WORK_DATA_O  <= TX_DATA_I;
            TX_PROT_DATA_O  <= TX_DATA_I;
            // 1:1 only carries traffic on the active line
            TX_WORK_VALID_O <= TX_VALID_I & ((scheme_reg != SLP_SCH_1T1) | WORK_ACTIVE_O);
            TX_PROT_VALID_O <= TX_VALID_I & ((scheme_reg != SLP_SCH_1T1) | PROT_ACTIVE_O);
            TX_APS_REQ_O    <= {work_fail, PROT_ACTIVE_O};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    chk_fail_switch: assert property (
        state_reg == SLP_ST_WORK && work_fail && !prot_alarm && !forced && !cfg_pulse
        |=> PROT_ACTIVE_O) else $error("failing working line not left");
    chk_wtr_return: assert property (
        state_reg == SLP_ST_WTR && tmr_exp && !work_fail && !far_prot && !forced && !cfg_pulse
        |=> WORK_ACTIVE_O ##1 !tmr_run) else $error("no return after wait-to-restore");
    chk_clear_return: assert property (
        $rose(WORK_ACTIVE_O) && !$past(cfg_pulse) && !$past(forced) |-> !$past(work_fail))
        else $error("returned to a failing working line");
    chk_cfg_default: assert property (
        cfg_pulse |=> rev_reg == (scheme_reg == SLP_SCH_1T1)) else $error("wrong revertive default");
    chk_one_active: assert property (
        WORK_ACTIVE_O != PROT_ACTIVE_O) else $error("line activity not exclusive");
    chk_annexb_mode: assert property (
        scheme_reg == SLP_SCH_ANXB |-> bidir_reg && !rev_reg) else $error("annex B mode broken");
    chk_manual_refused: assert property (
        man_wr && scheme_reg == SLP_SCH_ANXB |=> irq_reg[`SLP_IRQ_REFUSED] && $stable(manual_reg))
        else $error("annex B manual request not refused");
    chk_manual_force: assert property (
        forced && manual_reg == SLP_MAN_PROT && !cfg_pulse |=> PROT_ACTIVE_O)
        else $error("manual force ignored");
    chk_cfg_work: assert property (
        cfg_pulse |=> WORK_ACTIVE_O && !tmr_run) else $error("new pair not on working line");
    chk_bridge_both: assert property (
        scheme_reg != SLP_SCH_1T1 && TX_VALID_I |=> TX_WORK_VALID_O && TX_PROT_VALID_O
        && TX_WORK_DATA_O == TX_PROT_DATA_O) else $error("payload not bridged");
    chk_rx_select: assert property (
        PROT_ACTIVE_O && RX_PROT_VALID_I |=> RX_VALID_O && RX_DATA_O == $past(RX_PROT_DATA_I))
        else $error("receive not from protection line");
    chk_wtr_cancel: assert property (
        state_reg == SLP_ST_WTR && work_fail && !forced && !cfg_pulse |=> PROT_ACTIVE_O && !tmr_run)
        else $error("wait-to-restore not cancelled");

    cov_revert: cover property (state_reg == SLP_ST_WTR ##1 state_reg == SLP_ST_WORK);
    cov_force: cover property (forced && manual_reg == SLP_MAN_PROT ##1 PROT_ACTIVE_O);
    cov_reject: cover property (ev_reject);
    cov_far: cover property (far_prot && WORK_ACTIVE_O ##1 PROT_ACTIVE_O);
endmodule
`default_nettype wire

// ---- hw/slp_pkg.sv ----
// types shared by the line protection switch
`default_nettype none
package slp_pkg;
    typedef enum logic [1:0] {
        SLP_SCH_1P1  = 2'h0,
        SLP_SCH_1T1  = 2'h1,
        SLP_SCH_ANXB = 2'h2,
        SLP_SCH_RSVD = 2'h3
    } slp_scheme_t;
    typedef enum logic [1:0] {
        SLP_MAN_CLEAR = 2'h0,
        SLP_MAN_WORK  = 2'h1,
        SLP_MAN_PROT  = 2'h2,
        SLP_MAN_RSVD  = 2'h3
    } slp_manual_t;
    typedef enum logic [2:0] {
        SLP_ST_WORK = 3'b001,
        SLP_ST_PROT = 3'b010,
        SLP_ST_WTR  = 3'b100
    } slp_state_t;
endpackage
`default_nettype wire

// ---- hw/slp_regs.svh ----
// register map, field positions, reset values and timing counts of the line protection switch
`ifndef SLP_REGS_SVH
`define SLP_REGS_SVH

`define SLP_ADDR_CTRL       8'h00
`define SLP_ADDR_WTR        8'h04
`define SLP_ADDR_MANUAL     8'h08
`define SLP_ADDR_STATUS     8'h0c
`define SLP_ADDR_IRQ_STAT   8'h10
`define SLP_ADDR_IRQ_MASK   8'h14

`define SLP_CTRL_REV        2
`define SLP_CTRL_BIDIR      3
`define SLP_CTRL_PORT_LO    4
`define SLP_CTRL_CFG        7
`define SLP_CTRL_REAPPLY    8

`define SLP_ST_PROT_ACT     0
`define SLP_ST_WTR_RUN      1
`define SLP_ST_WORK_SF      2
`define SLP_ST_WORK_SD      3
`define SLP_ST_PROT_ALM     4
`define SLP_ST_MAN_ACT      5
`define SLP_ST_PART_CARD    6
`define SLP_ST_PART_PORT    8

`define SLP_IRQ_SWITCH      0
`define SLP_IRQ_REJECT      1
`define SLP_IRQ_REFUSED     2
`define SLP_IRQ_WTR_DONE    3
`define SLP_IRQ_W           4

`define SLP_WTR_RST         16'h012c
`define SLP_CLK_PERIOD_NS   40
`define SLP_WTR_UNIT_NS     1000000
`define SLP_WTR_UNIT_CYCLES (`SLP_WTR_UNIT_NS / `SLP_CLK_PERIOD_NS)

`endif

// ---- hw/slp_wtr_timer.sv ----
// wait-to-restore timer counting in units of a prescaled tick
`timescale 1ns/1ps
`default_nettype none
`include "slp_regs.svh"
module slp_wtr_timer #(
    parameter int unsigned UNIT_CYCLES = `SLP_WTR_UNIT_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        cancel_i,
    input  wire logic [15:0] period_i,
    output logic             running_o,
    output logic             expired_o
);
    logic [15:0] pre_reg, pre_next;
    logic [15:0] cnt_reg, cnt_next;
    logic        run_reg, run_next;
    logic        exp_reg, exp_next;

    always_comb begin
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        run_next = run_reg;
        exp_next = 1'b0;
        // cancel beats start so a renewed fail never leaves a stale wait
        if (cancel_i) begin
            run_next = 1'b0;
        end else if (start_i) begin
            run_next = 1'b1;
            cnt_next = period_i;
            pre_next = 16'h0000;
        end else if (run_reg) begin
            if (pre_reg == 16'(UNIT_CYCLES - 1)) begin
                pre_next = 16'h0000;
                if (cnt_reg <= 16'h0001) begin
                    run_next = 1'b0;
                    exp_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end else begin
                pre_next = pre_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_reg <= 16'h0000;
            cnt_reg <= 16'h0000;
            run_reg <= 1'b0;
            exp_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            exp_reg <= exp_next;
        end
    end

    assign running_o = run_reg;
    assign expired_o = exp_reg;
endmodule
`default_nettype wire

// ---- testbench/slp_far_end.sv ----
// far-end line terminating equipment model
`timescale 1ns/1ps
`default_nettype none
module slp_far_end (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] req_cmd_i,
    input  wire logic       mark_prot_i,
    output logic      [1:0] rx_req_o,
    output logic      [7:0] work_data_o,
    output logic            work_valid_o,
    output logic      [7:0] prot_data_o,
    output logic            prot_valid_o
);
    logic [6:0] cnt_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            cnt_reg <= 7'h00;
        else
            cnt_reg <= cnt_reg + 7'h01;
    end
    assign rx_req_o     = req_cmd_i;
    // marking bit 7 on protection is only a data tag, not an alarm, so the bench can tell lines apart
    assign work_data_o  = {1'b0, cnt_reg};
    assign prot_data_o  = {mark_prot_i, cnt_reg};
    assign work_valid_o = 1'b1;
    assign prot_valid_o = 1'b1;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the line protection switch
`timescale 1ns/1ps
`default_nettype none
`include "slp_regs.svh"
module tb
    import slp_pkg::*;
;
    logic        clk, rst, cyc, stb, we, tx_v, mark, ack, irq, fw_v, fp_v, rx_v, tw_v, tp_v, wact, pact;
    logic [7:0]  adr, tx_d, fw_d, fp_d, rx_d, tw_d, tp_d;
    logic [31:0] wdat, rdat;
    logic [4:0]  walm, palm;
    logic [1:0]  req_cmd, rx_req, tx_req;
    logic [31:0] exp_q[$];
    int          failures, cmp_count;
    slp_line_protect #(.WTR_UNIT_CYCLES(4)) dut (.CLK_SYS_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .IRQ_O(irq), .WORK_LOS_I(walm[0]), .WORK_LOF_I(walm[1]), .WORK_AIS_I(walm[2]), .WORK_BER_SF_I(walm[3]),
        .WORK_BER_SD_I(walm[4]), .PROT_LOS_I(palm[0]), .PROT_LOF_I(palm[1]), .PROT_AIS_I(palm[2]),
        .PROT_BER_SF_I(palm[3]), .PROT_BER_SD_I(palm[4]), .RX_APS_REQ_I(rx_req), .TX_APS_REQ_O(tx_req),
        .RX_WORK_DATA_I(fw_d), .RX_WORK_VALID_I(fw_v), .RX_PROT_DATA_I(fp_d), .RX_PROT_VALID_I(fp_v),
        .RX_DATA_O(rx_d), .RX_VALID_O(rx_v), .TX_DATA_I(tx_d), .TX_VALID_I(tx_v), .TX_WORK_DATA_O(tw_d),
        .TX_WORK_VALID_O(tw_v), .TX_PROT_DATA_O(tp_d), .TX_PROT_VALID_O(tp_v), .WORK_ACTIVE_O(wact),
        .PROT_ACTIVE_O(pact));
    slp_far_end far (.clk_i(clk), .rst_i(rst), .req_cmd_i(req_cmd), .mark_prot_i(mark), .rx_req_o(rx_req),
        .work_data_o(fw_d), .work_valid_o(fw_v), .prot_data_o(fp_d), .prot_valid_o(fp_v));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask
    task automatic tx_chk(input logic pv);
        logic [7:0] r;
        r = 8'($urandom);
        tx_d <= r;
        tx_v <= 1'b1;
        @(posedge clk);
        tx_v <= 1'b0;
        @(posedge clk);
        check({tw_v, tw_d, tp_v, pv ? tp_d : 8'h00}, {1'b1, r, pv, pv ? r : 8'h00});
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // read data is judged where the acknowledge shows, against the oldest note
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0)
            check(rdat, exp_q.pop_front());
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 6000);
        failures++;
        finish_test();
    end
    initial begin
        int n;
        {rst, cyc, stb, we, tx_v, mark} = 6'h21;
        {adr, tx_d, wdat, walm, palm, req_cmd} = 60'h0;
        void'($urandom(32'hc85335e6));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        check({wact, pact}, 2'b10);
        rd(`SLP_ADDR_CTRL, 32'h0);
        rd(`SLP_ADDR_WTR, 32'h12c);
        rd(8'h18, 32'h0);
        wb(`SLP_ADDR_WTR, 1'b1, 32'h2);
        wb(`SLP_ADDR_CTRL, 1'b1, 32'hb0 | SLP_SCH_1T1);
        rd(`SLP_ADDR_CTRL, 32'h35);
        rd(`SLP_ADDR_STATUS, 32'h400);
        tx_chk(1'b0);
        check({rx_v, rx_d[7]}, 2'b10);
        for (int i = 0; i < 5; i++) begin
            walm[i] <= 1'b1;
            repeat (3) @(posedge clk);
            check({wact, pact, tx_req, irq}, {4'b0111, i != 0});
            if (i == 0)
                wb(`SLP_ADDR_IRQ_MASK, 1'b1, 32'hf);
            wb(`SLP_ADDR_IRQ_STAT, 1'b1, 32'hf);
            check(irq, 1'b0);
            walm[i] <= 1'b0;
            if (i == 0) begin
                repeat (4) @(posedge clk);
                walm[i] <= 1'b1;
                repeat (20) @(posedge clk);
                check(pact, 1'b1);
                walm[i] <= 1'b0;
            end
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (wact !== 1'b1);
            check(n >= 8 && n <= 14, 1'b1);
        end
        for (int k = 0; k < 5; k++) begin
            palm[k] <= 1'b1;
            walm[0] <= 1'b1;
            repeat (3) @(posedge clk);
            check(wact, 1'b1);
            {palm[k], walm[0]} <= 2'b00;
            @(posedge clk);
        end
        wb(`SLP_ADDR_CTRL, 1'b1, 32'h80 | SLP_SCH_ANXB);
        wb(`SLP_ADDR_IRQ_STAT, 1'b1, 32'hf);
        wb(`SLP_ADDR_CTRL, 1'b1, 32'hc | SLP_SCH_ANXB);
        wb(`SLP_ADDR_CTRL, 1'b1, 32'h0 | SLP_SCH_ANXB);
        wb(`SLP_ADDR_MANUAL, 1'b1, SLP_MAN_PROT);
        rd(`SLP_ADDR_CTRL, 32'ha);
        rd(`SLP_ADDR_IRQ_STAT, 32'h6);
        check(wact, 1'b1);
        req_cmd <= 2'h1;
        repeat (2) @(posedge clk);
        check(pact, 1'b1);
        req_cmd <= 2'h0;
        wb(`SLP_ADDR_CTRL, 1'b1, 32'hb4 | SLP_SCH_1P1);
        rd(`SLP_ADDR_CTRL, 32'h30);
        rd(`SLP_ADDR_STATUS, 32'h340);
        tx_chk(1'b1);
        wb(`SLP_ADDR_MANUAL, 1'b1, SLP_MAN_PROT);
        @(posedge clk);
        check({pact, rx_v, rx_d[7]}, 3'b111);
        wb(`SLP_ADDR_CTRL, 1'b1, 32'hb0);
        rd(`SLP_ADDR_MANUAL, 32'h2);
        check(wact, 1'b1);
        wb(`SLP_ADDR_CTRL, 1'b1, 32'h130);
        @(posedge clk);
        check(pact, 1'b1);
        wb(`SLP_ADDR_MANUAL, 1'b1, SLP_MAN_CLEAR);
        @(posedge clk);
        check(wact, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
